// ==== dv/bridge_status_regs_asserts.sv ====
// Checker for the status header bank; it sees only the top ports.
// Assumes the event strobes are single-cycle pulses.
`timescale 1ns/100ps
module bridge_status_regs_asserts (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Inputs behind the status bits.
  input wire logic reverse_mode,
  input wire logic primary_pci_mode,
  input wire logic intx_pending,
  input wire logic fwd_poisoned_tlp_seen,
  input wire logic rev_parity_error_seen,
  // Outputs watched.
  input wire logic hresp,
  input wire logic parity_response_enable,
  input wire logic [7:0] cache_line_length,
  input wire logic [15:0] primary_status
);
  // ************************************************************
  // Properties. The status copy lags its sources by one edge, so
  // the live bits are compared with the inputs of the last edge.
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_INTX: assert property (
    $past(hresetn) |-> primary_status[3] == $past(intx_pending))
    else $error("interrupt pending bit wrong");
  AST_CAP: assert property (
    $past(hresetn) |-> primary_status[4]) else $error("cap bit low");
  AST_SPEED: assert property (
    $past(hresetn) |-> primary_status[5] == $past(reverse_mode))
    else $error("speed bit wrong");
  AST_B2B: assert property (
    $past(hresetn) |->
    primary_status[7] == $past(reverse_mode && primary_pci_mode))
    else $error("back-to-back bit wrong");
  AST_DEVSEL: assert property (
    $past(hresetn) |->
    primary_status[10:9] == {1'b0, $past(reverse_mode)})
    else $error("select timing wrong");
  AST_RSVD: assert property (
    primary_status[2:0] == 3'h0 && !primary_status[6])
    else $error("reserved status bit set");
  AST_CACHE: assert property (
    (cache_line_length & 8'hC3) == 8'h00) else $error("cache bits set");
  AST_GATE: assert property (
    $rose(primary_status[8]) |-> $past(parity_response_enable, 2))
    else $error("parity flag set while disabled");
  AST_DETECT: assert property (
    (fwd_poisoned_tlp_seen && !reverse_mode) ||
    (rev_parity_error_seen && reverse_mode) |-> ##2 primary_status[15])
    else $error("detected parity flag not set");
  AST_OKAY: assert property (hresp == bridge_status_pkg::HRESP_OKAY)
    else $error("response not okay");
endmodule

bind bridge_status_regs bridge_status_regs_asserts u_chk (
  .hclk(hclk), .hresetn(hresetn), .reverse_mode(reverse_mode),
  .primary_pci_mode(primary_pci_mode), .intx_pending(intx_pending),
  .fwd_poisoned_tlp_seen(fwd_poisoned_tlp_seen),
  .rev_parity_error_seen(rev_parity_error_seen), .hresp(hresp),
  .parity_response_enable(parity_response_enable),
  .cache_line_length(cache_line_length), .primary_status(primary_status)
);

// ==== dv/bridge_status_regs_tb.sv ====
// Self-checking bench for the status header bank.
// Assumes the bank is the only slave and hready loops from hreadyout.
`timescale 1ns/100ps
module bridge_status_regs_tb;
  // Revision value is arbitrary.
  localparam logic [7:0] REV = 8'h5A;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, d, q;
  logic hreadyout, hresp, pre_out;
  logic reverse_mode = 1'b0;
  logic primary_pci_mode = 1'b0;
  logic intx_pending = 1'b0;
  logic req = 1'b0;
  logic [3:0] idx = 4'h0;
  logic [14:0] ev;
  logic [7:0] cll;
  logic [15:0] pst;
  // Model state: sticky flags and the parity response bit.
  logic [31:0] flags_m = 32'h0;
  logic pre_m = 1'b0;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed = 20;
  // Status bit set by each strobe, forward set first.
  int tgt [15] = '{24,24,27,28,29,30,31,24,24,24,27,28,29,30,31};

  always #12.5 hclk = ~hclk;

  bridge_status_regs #(.REVISION(REV)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .reverse_mode(reverse_mode),
    .primary_pci_mode(primary_pci_mode), .intx_pending(intx_pending),
    .fwd_poisoned_cpl_rx(ev[0]), .fwd_poisoned_write_tx(ev[1]),
    .fwd_completer_abort_sent(ev[2]), .fwd_cpl_abort_rx(ev[3]),
    .fwd_cpl_unsupported_rx(ev[4]), .fwd_error_msg_sent(ev[5]),
    .fwd_poisoned_tlp_seen(ev[6]), .rev_read_parity_error(ev[7]),
    .rev_primary_parity_error_pin_seen(ev[8]),
    .rev_split_msg_parity_error(ev[9]),
    .rev_target_abort_signaled(ev[10]), .rev_target_abort_seen(ev[11]),
    .rev_master_abort_seen(ev[12]),
    .rev_system_error_pin_driven(ev[13]),
    .rev_parity_error_seen(ev[14]), .parity_response_enable(pre_out),
    .cache_line_length(cll), .primary_status(pst));

  event_source partner (.hclk(hclk), .hresetn(hresetn), .req(req),
    .idx(idx), .ev(ev));

  // Expected status word from the model and the live inputs.
  function automatic logic [31:0] exp04();
    logic [31:0] w;
    w = flags_m;
    w[6] = pre_m;
    w[19] = intx_pending;
    w[20] = 1'b1;
    w[21] = reverse_mode;
    w[23] = reverse_mode & primary_pci_mode;
    w[25] = reverse_mode;
    return w;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One single transfer; entered just after a rising edge.
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0, q);
    chk($sformatf("word %h", a), e, q);
    // Every transfer must be answered OKAY.
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // A hang is cut short well past the expected run length.
  always @(posedge hclk) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(8'h04, exp04());
    xfer(8'h08, 1'b1, 32'hFFFFFFFF, q);
    rd_chk(8'h08, {8'h06, 8'h80, 8'h00, REV});
    rd_chk(8'h0C, 32'h0);
    rd_chk(8'h20, 32'h0);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      reverse_mode <= m[0];
      primary_pci_mode <= m[1];
      // The first two passes force both levels; the rest are random.
      intx_pending <= (m < 2) ? m[0] : 1'($random(seed));
      @(posedge hclk);
      rd_chk(8'h04, exp04());
    end
    $display("test modes done");
    for (int k = 0; k < 6; k++) begin
      d = (k == 0) ? 32'hFFFFFFFF : $random(seed);
      xfer(8'h0C, 1'b1, d, q);
      rd_chk(8'h0C, d & 32'h3C);
      chk("cache out", d & 32'h3C, {24'h0, cll});
    end
    $display("test cache done");
    for (int m = 0; m < 4; m++) begin
      reverse_mode <= m[0];
      pre_m = m[1];
      xfer(8'h04, 1'b1, {25'h0, pre_m, 6'h0}, q);
      // The write lands at the edge that ends xfer, so the register
      // output is only settled one edge later.
      @(posedge hclk);
      chk("parity enable", {31'h0, pre_m}, {31'h0, pre_out});
      for (int i = 0; i < 15; i++) begin
        req <= 1'b1;
        idx <= i[3:0];
        @(posedge hclk);
        req <= 1'b0;
        repeat (2) @(posedge hclk);
        if ((i > 6) == m[0] && (tgt[i] != 24 || pre_m)) flags_m[tgt[i]] = 1'b1;
        rd_chk(8'h04, exp04());
        chk("status out", exp04() >> 16, {16'h0, pst});
      end
      xfer(8'h04, 1'b1, {25'h0, pre_m, 6'h0}, q);
      rd_chk(8'h04, exp04());
      xfer(8'h04, 1'b1, 32'hFFFFFFBF | {25'h0, pre_m, 6'h0}, q);
      flags_m = 32'h0;
      rd_chk(8'h04, exp04());
    end
    $display("test events done");
    tally_and_finish();
  end
endmodule

// ==== dv/event_source.sv ====
// Stand-in for the transaction logic that raises event strobes.
// Assumes requests arrive just after a rising edge.
`timescale 1ns/100ps
module event_source (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Request: which strobe to pulse.
  input wire logic req,
  input wire logic [3:0] idx,
  // Strobes in the bench's table order.
  output logic [14:0] ev
);
  // A level would set a flag again right after a clear, so every
  // request makes exactly one single-cycle pulse.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev <= 15'h0000;
    end else begin
      ev <= req ? (15'h0001 << idx) : 15'h0000;
    end
  end
endmodule

// ==== hw/bridge_status_regs.sv ====
// Primary status, class code and cache line size register bank.
// Assumes a single AHB-Lite master, whole-word transfers, and event
// strobes from the transaction logic that are one-cycle pulses.
`timescale 1ns/100ps
module bridge_status_regs #(
  parameter logic [7:0] REVISION = bridge_status_pkg::REVISION_DEFAULT
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave port.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Operating mode straps.
  input wire logic reverse_mode,
  input wire logic primary_pci_mode,
  // Live state.
  input wire logic intx_pending,
  // Forward bridge event strobes.
  input wire logic fwd_poisoned_cpl_rx,
  input wire logic fwd_poisoned_write_tx,
  input wire logic fwd_completer_abort_sent,
  input wire logic fwd_cpl_abort_rx,
  input wire logic fwd_cpl_unsupported_rx,
  input wire logic fwd_error_msg_sent,
  input wire logic fwd_poisoned_tlp_seen,
  // Reverse bridge event strobes.
  input wire logic rev_read_parity_error,
  input wire logic rev_primary_parity_error_pin_seen,
  input wire logic rev_split_msg_parity_error,
  input wire logic rev_target_abort_signaled,
  input wire logic rev_target_abort_seen,
  input wire logic rev_master_abort_seen,
  input wire logic rev_system_error_pin_driven,
  input wire logic rev_parity_error_seen,
  // Register values seen by the rest of the bridge.
  output logic parity_response_enable,
  output logic [7:0] cache_line_length,
  output logic [15:0] primary_status
);

  // ************************************************************
  // Bus capture.
  // ************************************************************

  // Current slave phase.
  bridge_status_pkg::bus_state_t bus_state_reg;
  // Word address held from the address phase.
  logic [7:0] addr_reg;
  // High during the data phase of an accepted write.
  logic write_pend_reg;
  // Accepted transfer in this cycle's address phase.
  logic accept;

  // A transfer counts only when selected, NONSEQ or SEQ, and the bus
  // is ready; hsize is not checked because only whole words are used.
  assign accept = hsel && htrans[1] && hready;

  // The slave phase: writes finish with no wait, reads take one wait
  // state so that a read right after a write sees the written value.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state_reg <= bridge_status_pkg::BUS_IDLE;
    end else begin
      case (bus_state_reg)
        bridge_status_pkg::BUS_IDLE: begin
          // A read moves to the wait state.
          if (accept && !hwrite) begin
            bus_state_reg <= bridge_status_pkg::BUS_READ_WAIT;
          end
        end
        bridge_status_pkg::BUS_READ_WAIT: begin
          // Data is loaded now; back to idle.
          bus_state_reg <= bridge_status_pkg::BUS_IDLE;
        end
        default: begin
          bus_state_reg <= bridge_status_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // Address and write flag of the transfer now in its data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= 8'h00;
      write_pend_reg <= 1'b0;
    end else begin
      write_pend_reg <= accept && hwrite;
      if (accept) begin
        addr_reg <= {haddr[7:2], 2'b00};
      end
    end
  end

  // Ready drops for exactly the one wait cycle of a read.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= !(accept && !hwrite &&
                     bus_state_reg == bridge_status_pkg::BUS_IDLE);
    end
  end

  // Every transfer is answered OKAY, unmapped ones included.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= bridge_status_pkg::HRESP_OKAY;
    end else begin
      hresp <= bridge_status_pkg::HRESP_OKAY;
    end
  end

  // ************************************************************
  // Write decode.
  // ************************************************************

  // Write strobes to each word.
  logic wr_cmd_status;
  logic wr_cache_line;

  assign wr_cmd_status =
    write_pend_reg && addr_reg == bridge_status_pkg::CMD_STATUS_OFF;
  assign wr_cache_line =
    write_pend_reg && addr_reg == bridge_status_pkg::CACHE_LINE_OFF;

  // Parity response enable in the command half.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      parity_response_enable <= bridge_status_pkg::PARITY_RESP_RESET;
    end else if (wr_cmd_status) begin
      parity_response_enable <=
        hwdata[bridge_status_pkg::PARITY_RESP_BIT];
    end
  end

  // Cache line size: unsupported bits are masked off on every write.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cache_line_length <= bridge_status_pkg::CACHE_LINE_RESET;
    end else if (wr_cache_line) begin
      cache_line_length <=
        hwdata[7:0] & bridge_status_pkg::CACHE_LINE_MASK;
    end
  end

  // ************************************************************
  // Sticky error flags.
  // ************************************************************

  // Parity flag set term and the other sticky set and clear terms.
  logic parity_set;
  logic parity_flag;
  logic [bridge_status_pkg::STICKY_COUNT-1:0] sticky_set;
  logic [bridge_status_pkg::STICKY_COUNT-1:0] sticky_clear;
  logic [bridge_status_pkg::STICKY_COUNT-1:0] sticky_flags;
  logic [bridge_status_pkg::STICKY_COUNT:0] all_set;
  logic [bridge_status_pkg::STICKY_COUNT:0] all_clear;
  logic [bridge_status_pkg::STICKY_COUNT:0] all_flags;

  // The master parity flag listens only while parity response is on;
  // the event set differs between the two bridge directions.
  always_comb begin
    if (reverse_mode) begin
      parity_set = parity_response_enable &&
        (rev_read_parity_error || rev_primary_parity_error_pin_seen ||
         rev_split_msg_parity_error);
    end else begin
      parity_set = parity_response_enable &&
        (fwd_poisoned_cpl_rx || fwd_poisoned_write_tx);
    end
  end

  // Remaining flags pick their event by direction.
  always_comb begin
    if (reverse_mode) begin
      sticky_set[0] = rev_target_abort_signaled;
      sticky_set[1] = rev_target_abort_seen;
      sticky_set[2] = rev_master_abort_seen;
      sticky_set[3] = rev_system_error_pin_driven;
      sticky_set[4] = rev_parity_error_seen;
    end else begin
      sticky_set[0] = fwd_completer_abort_sent;
      sticky_set[1] = fwd_cpl_abort_rx;
      sticky_set[2] = fwd_cpl_unsupported_rx;
      sticky_set[3] = fwd_error_msg_sent;
      sticky_set[4] = fwd_poisoned_tlp_seen;
    end
  end

  // Writing one to a flag position clears that flag only.
  assign sticky_clear = {bridge_status_pkg::STICKY_COUNT{wr_cmd_status}} &
    hwdata[bridge_status_pkg::DETECTED_PARITY_BIT:
           bridge_status_pkg::STICKY_LO_BIT];

  assign all_set = {sticky_set, parity_set};
  assign all_clear = {sticky_clear, wr_cmd_status &&
    hwdata[bridge_status_pkg::MASTER_PARITY_BIT]};
  assign parity_flag = all_flags[0];
  assign sticky_flags = all_flags[bridge_status_pkg::STICKY_COUNT:1];

  // One bank holds all six write-one-to-clear flags.
  w1c_flags #(
    .WIDTH(bridge_status_pkg::STICKY_COUNT + 1)
  ) u_flags (
    .hclk(hclk),
    .hresetn(hresetn),
    .set_pulse(all_set),
    .clear_pulse(all_clear),
    .flags(all_flags)
  );

  // ************************************************************
  // Status word assembly.
  // ************************************************************

  // Upper half of the command and status word, as software sees it.
  logic [15:0] status_now;

  // Capability bits follow the straps except the constant list bit, reserved bits stay zero.
  always_comb begin
    status_now = 16'h0000;
    status_now[bridge_status_pkg::INTX_PENDING_BIT-16] =
      intx_pending;
    status_now[bridge_status_pkg::CAP_LIST_BIT-16] =
      bridge_status_pkg::CAP_LIST_VALUE;
    status_now[bridge_status_pkg::CAPABLE_66_BIT-16] = reverse_mode;
    status_now[bridge_status_pkg::FAST_B2B_BIT-16] =
      reverse_mode && primary_pci_mode;
    status_now[bridge_status_pkg::MASTER_PARITY_BIT-16] = parity_flag;
    status_now[bridge_status_pkg::DEVSEL_HI_BIT-16:
               bridge_status_pkg::DEVSEL_LO_BIT-16] = reverse_mode ?
      bridge_status_pkg::DEVSEL_MEDIUM :
      bridge_status_pkg::DEVSEL_FAST;
    status_now[bridge_status_pkg::DETECTED_PARITY_BIT-16:
               bridge_status_pkg::STICKY_LO_BIT-16] = sticky_flags;
  end

  // Registered copy for the rest of the bridge.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      primary_status <= 16'h0000;
    end else begin
      primary_status <= status_now;
    end
  end

  // ************************************************************
  // Read data.
  // ************************************************************

  // Read mux over the mapped words.
  logic [31:0] read_word;

  always_comb begin
    case (addr_reg)
      bridge_status_pkg::CMD_STATUS_OFF: begin
        // Other command bits belong to logic outside this bank.
        read_word = {status_now, 16'h0000};
        read_word[bridge_status_pkg::PARITY_RESP_BIT] =
          parity_response_enable;
      end
      bridge_status_pkg::CLASS_REV_OFF: begin
        read_word = {bridge_status_pkg::BASE_CLASS_VALUE,
                     bridge_status_pkg::SUB_CLASS_VALUE,
                     bridge_status_pkg::PROG_IF_VALUE,
                     REVISION};
      end
      bridge_status_pkg::CACHE_LINE_OFF: begin
        // Latency timer and header type are not held here.
        read_word = {24'h000000, cache_line_length};
      end
      default: begin
        read_word = bridge_status_pkg::UNMAPPED_READ;
      end
    endcase
  end

  // Read data is loaded in the wait cycle and then held.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (bus_state_reg == bridge_status_pkg::BUS_READ_WAIT) begin
      hrdata <= read_word;
    end
  end

endmodule

// ==== hw/w1c_flags.sv ====
// Bank of sticky flags: hardware sets, software clears by writing one.
// Assumes set and clear strobes are synchronous to hclk.
`timescale 1ns/100ps
module w1c_flags #(
  parameter int WIDTH = 5
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Set and clear strobes, one per flag.
  input wire logic [WIDTH-1:0] set_pulse,
  input wire logic [WIDTH-1:0] clear_pulse,
  // Flag values.
  output logic [WIDTH-1:0] flags
);

  // ************************************************************
  // Flag cells.
  // ************************************************************

  // One cell per flag. A set in the same cycle as a clear wins, so an
  // error that lands while software is clearing the flag is not lost.
  for (genvar i = 0; i < WIDTH; i++) begin : g_flag
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        flags[i] <= 1'b0;
      end else if (set_pulse[i]) begin
        flags[i] <= 1'b1;
      end else if (clear_pulse[i]) begin
        flags[i] <= 1'b0;
      end
    end
  end

endmodule

// ==== inc/bridge_status_pkg.sv ====
// Shared constants for the primary-side status header register bank.
// Assumes a 32-bit AHB-Lite register bus with one word per register.
package bridge_status_pkg;

  // ************************************************************
  // Register byte offsets.
  // ************************************************************
  localparam logic [7:0] CMD_STATUS_OFF = 8'h04;
  localparam logic [7:0] CLASS_REV_OFF = 8'h08;
  localparam logic [7:0] CACHE_LINE_OFF = 8'h0C;

  // ************************************************************
  // Command half: only the parity response enable is held here.
  // ************************************************************
  localparam int PARITY_RESP_BIT = 6;
  localparam logic PARITY_RESP_RESET = 1'h0;

  // ************************************************************
  // Status half, bit positions within the 32-bit word.
  // ************************************************************
  localparam int INTX_PENDING_BIT = 19;
  localparam int CAP_LIST_BIT = 20;
  localparam int CAPABLE_66_BIT = 21;
  localparam int FAST_B2B_BIT = 23;
  localparam int MASTER_PARITY_BIT = 24;
  localparam int DEVSEL_LO_BIT = 25;
  localparam int DEVSEL_HI_BIT = 26;
  localparam int SIG_TARGET_ABORT_BIT = 27;
  localparam int RCV_TARGET_ABORT_BIT = 28;
  localparam int RCV_MASTER_ABORT_BIT = 29;
  localparam int SIG_SYSTEM_ERR_BIT = 30;
  localparam int DETECTED_PARITY_BIT = 31;

  // Sticky error flags sit in a contiguous run of bits.
  localparam int STICKY_LO_BIT = 27;
  localparam int STICKY_COUNT = 5;

  // Capability pointer location that the capability bit advertises.
  localparam logic [7:0] CAP_POINTER_OFF = 8'h34;
  localparam logic CAP_LIST_VALUE = 1'h1;

  // Device-select timing codes.
  localparam logic [1:0] DEVSEL_FAST = 2'h0;
  localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
  localparam logic [1:0] DEVSEL_SLOW = 2'h2;

  // ************************************************************
  // Class code and revision.
  // ************************************************************
  localparam logic [7:0] PROG_IF_VALUE = 8'h00;
  localparam logic [7:0] SUB_CLASS_VALUE = 8'h80;
  localparam logic [7:0] BASE_CLASS_VALUE = 8'h06;
  localparam int PROG_IF_LO_BIT = 8;
  // Revision default is arbitrary, not tied to any part.
  localparam logic [7:0] REVISION_DEFAULT = 8'h01;

  // ************************************************************
  // Cache line size: bits 5:2 writable, others read zero.
  // ************************************************************
  localparam logic [7:0] CACHE_LINE_MASK = 8'h3C;
  localparam logic [7:0] CACHE_LINE_RESET = 8'h00;

  // ************************************************************
  // Bus answer values.
  // ************************************************************
  localparam logic HRESP_OKAY = 1'h0;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

  // Bus slave phases.
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_READ_WAIT = 2'b10
  } bus_state_t;

endpackage
